// >>> common/filt_regs_pkg.sv
// Purpose: Shared constants, types and carriers for the filter status and OTP register group.
// Assumes: Registers are 24 bits wide and reached over the serial port, 7-bit address.
// Notes:   Timing counts are derived from the 10 MHz system clock.
`default_nettype none
package filt_regs_pkg;
    localparam int          DATA_W          = 24;
    localparam int          ADDR_W          = 7;
    localparam logic [5:0]  FRAME_BITS      = 6'd32;
    localparam logic [5:0]  HDR_BITS        = 6'd8;
    // Register offsets.
    localparam logic [6:0]  A_CAL_STROBE    = 7'h04;
    localparam logic [6:0]  A_CAL_STATUS    = 7'h08;
    localparam logic [6:0]  A_RAW_COUNT     = 7'h09;
    localparam logic [6:0]  A_NV_IMAGE      = 7'h0a;
    localparam logic [6:0]  A_NV_ENABLE     = 7'h0b;
    localparam logic [6:0]  A_NV_ADDR       = 7'h0c;
    localparam logic [6:0]  A_NV_STROBE     = 7'h0d;
    localparam logic [6:0]  A_ST_ENABLE     = 7'h0e;
    localparam logic [6:0]  A_ST_RESULT     = 7'h0f;
    localparam logic [6:0]  A_THR_FIRST     = 7'h10;
    localparam logic [6:0]  A_THR_LAST      = 7'h1a;
    // Field positions.
    localparam int          F_CAL_BUSY      = 4;
    localparam int          F_NV_BUSY       = 5;
    localparam int          F_ST_RUNNING    = 16;
    localparam int          F_NV_PRG_FLAG   = 13;
    localparam int          F_NV_RSVD       = 15;
    // Values after reset and limits.
    localparam logic        RST_NV_ENABLE   = 1'b0;
    localparam logic [3:0]  RST_NV_ADDR     = 4'h0;
    localparam logic        RST_ST_ENABLE   = 1'b0;
    localparam logic [15:0] RST_SIGNATURE   = 16'h0000;
    localparam logic [15:0] RST_NV_BITS     = 16'h0000;
    localparam logic [3:0]  FINE_CODE_MAX   = 4'hb;
    localparam logic [15:0] CRC_POLY        = 16'h1021;
    localparam logic [15:0] CRC_SEED        = 16'hffff;
    localparam logic [23:0] CODE_BASE_PS    = 24'h004e20;
    localparam int          CODE_STEP_SHIFT = 10;
    localparam int          MEAS_ADJ_SHIFT  = 10;
    // Timing.
    localparam longint      CLK_HZ          = 10_000_000;
    localparam longint      NV_PROG_TIME_NS = 100_000;
    localparam logic [9:0]  NV_PROG_CYCLES  = 10'((NV_PROG_TIME_NS * CLK_HZ) / 1_000_000_000);
    localparam logic [6:0]  BIST_CYCLES     = 7'd64;

    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_MEAS = 3'b010,
        CAL_BIST = 3'b100
    } cal_state_e;

    typedef struct packed {
        logic        busy;
        logic        st_running;
        logic [3:0]  code;
        logic [23:0] raw_count;
        logic [15:0] signature;
    } cal_stat_s;

    typedef struct packed {
        logic [15:0] image;
        logic        busy;
    } nv_stat_s;
endpackage
`default_nettype wire

// >>> hdl/nv_store.sv
// Purpose: One-time-programmable bit store with a timed burn of one addressed bit.
// Assumes: Strobe and controls come from logic on the same clock.
// Notes:   Bits only go from zero to one between resets; a reset clears every burned bit back to zero.
`timescale 1ns/1ps
`default_nettype none
module nv_store (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_reset,
    input  wire logic                  i_clk_en,
    input  wire logic                  i_strobe,
    input  wire logic                  i_enable,
    input  wire logic [3:0]            i_addr,
    output filt_regs_pkg::nv_stat_s    o_stat
);
    import filt_regs_pkg::*;
    typedef struct packed {
        logic [15:0] bits;
        logic        busy;
        logic [3:0]  addr;
        logic [9:0]  timer;
    } nv_reg_s;
    nv_reg_s s, next_s;

    // A strobe starts a burn only while programming is enabled and no burn runs.
    always_comb begin
        next_s = s;
        if (s.busy) begin
            if (s.timer == 10'h000) begin
                next_s.bits[s.addr] = 1'b1;
                next_s.busy = 1'b0;
            end else begin
                next_s.timer = s.timer - 10'h001;
            end
        end else if (i_strobe && i_enable) begin
            next_s.busy = 1'b1;
            next_s.addr = i_addr;
            next_s.timer = NV_PROG_CYCLES - 10'h001;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            s <= '{bits: RST_NV_BITS, busy: 1'b0, addr: 4'h0, timer: 10'h000};
        end else if (i_clk_en) begin
            s <= next_s;
        end
    end

    assign o_stat.image = s.bits;
    assign o_stat.busy  = s.busy;
endmodule
`default_nettype wire

// >>> hdl/cal_engine.sv
// Purpose: RC calibration counter, fine code decode and built-in self-test signature.
// Assumes: i_rc_done comes from the analog comparator and is asynchronous.
// Notes:   The correction value only feeds the decode, never the raw count.
`timescale 1ns/1ps
`default_nettype none
module cal_engine #(
    parameter logic [23:0] BASE_PS = filt_regs_pkg::CODE_BASE_PS
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_reset,
    input  wire logic                  i_clk_en,
    input  wire logic                  i_start,
    input  wire logic                  i_bist,
    input  wire logic                  i_rc_done,
    input  wire logic [14:0]           i_clock_period,
    input  wire logic [8:0]            i_meas_adj,
    output filt_regs_pkg::cal_stat_s   o_stat
);
    import filt_regs_pkg::*;
    typedef struct packed {
        cal_state_e  state;
        logic        rc_s1;
        logic        rc_s2;
        logic [3:0]  code;
        logic [23:0] count;
        logic [15:0] crc;
        logic [15:0] signature;
        logic [6:0]  left;
    } cal_reg_s;
    cal_reg_s s, next_s;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int k = 15; k >= 0; k--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[k]) ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    logic [24:0] sum;
    logic [23:0] cnt_nxt;
    logic [25:0] adj;
    logic [25:0] over;
    logic [3:0]  dec;
    // Saturating accumulate, then signed correction and clamp to the legal code range.
    always_comb begin
        sum  = {1'b0, s.count} + {10'h000, i_clock_period};
        // Decoding the saturated next count keeps the code in step with the count read back.
        cnt_nxt = sum[24] ? 24'hffffff : sum[23:0];
        adj  = $signed({2'b00, cnt_nxt}) + ($signed({{17{i_meas_adj[8]}}, i_meas_adj}) <<< MEAS_ADJ_SHIFT);
        over = adj - {2'b00, BASE_PS};
        if (adj[25] || over[25]) begin
            dec = 4'h0;
        end else if ((over >> CODE_STEP_SHIFT) > 26'(FINE_CODE_MAX)) begin
            dec = FINE_CODE_MAX;
        end else begin
            dec = 4'(over >> CODE_STEP_SHIFT);
        end
    end

    always_comb begin
        next_s = s;
        next_s.rc_s1 = i_rc_done;
        next_s.rc_s2 = s.rc_s1;
        case (s.state)
            CAL_IDLE: begin
                if (i_start) begin
                    next_s.count = 24'h000000;
                    next_s.crc = CRC_SEED;
                    next_s.left = BIST_CYCLES;
                    next_s.state = i_bist ? CAL_BIST : CAL_MEAS;
                end
            end
            CAL_MEAS: begin
                next_s.count = cnt_nxt;
                if (s.rc_s2 || sum[24]) begin
                    next_s.code = dec;
                    next_s.state = CAL_IDLE;
                end
            end
            CAL_BIST: begin
                next_s.count = sum[23:0];
                next_s.crc = crc_step(s.crc, s.count[15:0]);
                next_s.left = s.left - 7'd1;
                if (s.left == 7'd1) begin
                    next_s.signature = next_s.crc;
                    next_s.state = CAL_IDLE;
                end
            end
            default: next_s.state = CAL_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            s <= '{state: CAL_IDLE, rc_s1: 1'b0, rc_s2: 1'b0, code: 4'h0, count: 24'h000000,
                   crc: CRC_SEED, signature: RST_SIGNATURE, left: 7'd0};
        end else if (i_clk_en) begin
            s <= next_s;
        end
    end

    assign o_stat.busy       = (s.state == CAL_MEAS);
    assign o_stat.st_running = (s.state == CAL_BIST);
    assign o_stat.code       = s.code;
    assign o_stat.raw_count  = s.count;
    assign o_stat.signature  = s.signature;
endmodule
`default_nettype wire

// >>> hdl/filt_status_regs.sv
// Purpose: Serial port slave and the calibration status, OTP and self-test register group.
// Assumes: The serial clock is at least eight times slower than the system clock.
// Notes:   Frame is 32 bits MSB first: read flag, 7-bit address, 24-bit data.
`timescale 1ns/1ps
`default_nettype none
module filt_status_regs (
    input  wire logic               i_clk_sys,
    input  wire logic               i_reset,
    input  wire logic               i_clk_en,
    input  wire logic               i_spi_clk,
    input  wire logic               i_spi_sel_n,
    input  wire logic               i_spi_mosi,
    output logic                    o_spi_miso,
    output logic                    o_spi_miso_oe,
    input  wire logic               i_rc_done,
    input  wire logic               i_force_code,
    input  wire logic [3:0]         i_fine_override,
    input  wire logic [14:0]        i_clock_period,
    input  wire logic [8:0]         i_meas_adj,
    input  wire logic               i_settings_bit0,
    output logic                    o_settings_bit0_eff,
    output logic [3:0]              o_fine_code_eff,
    output logic [15:0]             o_stored_settings
);
    import filt_regs_pkg::*;

    typedef struct packed {
        logic        sclk_s1;
        logic        sclk_s2;
        logic        sclk_d;
        logic        sel_n_s1;
        logic        sel_n_s2;
        logic        mosi_s1;
        logic        mosi_s2;
        logic [5:0]  bit_cnt;
        logic [31:0] shift_in;
        logic [23:0] shift_out;
        logic        reading;
        logic        miso;
        logic        miso_oe;
        logic        wr_go;
        logic [6:0]  wr_addr;
        logic [23:0] wr_data;
        logic        cal_start;
        logic        nv_strobe;
        logic        nv_program_enable;
        logic [3:0]  nv_addr;
        logic        self_test_mode_on;
        logic [3:0]  fine_eff;
        logic        bit0_eff;
    } top_reg_s;
    top_reg_s s, next_s;

    cal_stat_s cal;
    nv_stat_s  nv;

    // The engine picks self-test or normal calibration from the mode bit at start.
    cal_engine u_cal (
        .i_clk_sys      (i_clk_sys),
        .i_reset        (i_reset),
        .i_clk_en       (i_clk_en),
        .i_start        (s.cal_start),
        .i_bist         (s.self_test_mode_on),
        .i_rc_done      (i_rc_done),
        .i_clock_period (i_clock_period),
        .i_meas_adj     (i_meas_adj),
        .o_stat         (cal)
    );

    // The burn itself is timed inside the store; this side only strobes it.
    nv_store u_nv (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_strobe  (s.nv_strobe),
        .i_enable  (s.nv_program_enable),
        .i_addr    (s.nv_addr),
        .o_stat    (nv)
    );

    // Read data for one address; unmapped and reserved addresses read zero.
    function automatic logic [23:0] read_mux(input logic [6:0] a);
        logic [23:0] r;
        r = 24'h000000;
        case (a)
            A_CAL_STATUS: begin
                r[3:0] = cal.code;
                r[F_CAL_BUSY] = cal.busy;
                r[F_NV_BUSY] = nv.busy;
            end
            A_RAW_COUNT: r = cal.raw_count;
            A_NV_IMAGE: begin
                r[15:0] = nv.image;
                r[F_NV_RSVD] = 1'b0;
            end
            A_NV_ENABLE: r[0] = s.nv_program_enable;
            A_NV_ADDR: r[3:0] = s.nv_addr;
            A_ST_ENABLE: r[0] = s.self_test_mode_on;
            A_ST_RESULT: begin
                r[15:0] = cal.signature;
                r[F_ST_RUNNING] = cal.st_running;
            end
            default: r = 24'h000000;
        endcase
        return r;
    endfunction

    logic        sclk_rise;
    logic        sclk_fall;
    logic        selected;
    logic [31:0] frame_nxt;
    // Edges are found on the second synchroniser stage and its delayed copy only.
    always_comb begin
        sclk_rise = s.sclk_s2 & ~s.sclk_d;
        sclk_fall = ~s.sclk_s2 & s.sclk_d;
        selected  = ~s.sel_n_s2;
        frame_nxt = {s.shift_in[30:0], s.mosi_s2};
    end

    // Serial slave, write decode and derived outputs in one next-state process.
    always_comb begin
        next_s = s;
        next_s.sclk_s1 = i_spi_clk;
        next_s.sclk_s2 = s.sclk_s1;
        next_s.sclk_d = s.sclk_s2;
        next_s.sel_n_s1 = i_spi_sel_n;
        next_s.sel_n_s2 = s.sel_n_s1;
        next_s.mosi_s1 = i_spi_mosi;
        next_s.mosi_s2 = s.mosi_s1;
        next_s.wr_go = 1'b0;
        next_s.cal_start = 1'b0;
        next_s.nv_strobe = 1'b0;
        // A deselect aborts any partial frame, so a short frame never writes.
        if (!selected) begin
            next_s.bit_cnt = 6'd0;
            next_s.reading = 1'b0;
            next_s.miso_oe = 1'b0;
            next_s.miso = 1'b0;
        end else if (sclk_rise && s.bit_cnt < FRAME_BITS) begin
            next_s.shift_in = frame_nxt;
            next_s.bit_cnt = s.bit_cnt + 6'd1;
            if (s.bit_cnt == HDR_BITS - 6'd1) begin
                next_s.reading = frame_nxt[7];
                next_s.shift_out = read_mux(frame_nxt[6:0]);
            end
            if (s.bit_cnt == FRAME_BITS - 6'd1 && !s.reading) begin
                next_s.wr_go = 1'b1;
                next_s.wr_addr = frame_nxt[30:24];
                next_s.wr_data = frame_nxt[23:0];
            end
        end else if (sclk_fall && s.reading && s.bit_cnt >= HDR_BITS) begin
            next_s.miso = s.shift_out[23];
            next_s.shift_out = {s.shift_out[22:0], 1'b0};
            next_s.miso_oe = 1'b1;
        end
        // Write decode one cycle after the frame's last bit.
        if (s.wr_go) begin
            case (s.wr_addr)
                A_CAL_STROBE: next_s.cal_start = 1'b1;
                A_NV_ENABLE: next_s.nv_program_enable = s.wr_data[0];
                A_NV_ADDR: next_s.nv_addr = s.wr_data[3:0];
                A_NV_STROBE: next_s.nv_strobe = 1'b1;
                A_ST_ENABLE: next_s.self_test_mode_on = s.wr_data[0];
                default: next_s.cal_start = 1'b0;
            endcase
        end
        next_s.fine_eff = i_force_code ? i_fine_override : cal.code;
        next_s.bit0_eff = nv.image[F_NV_PRG_FLAG] & i_settings_bit0;
    end

    // All state freezes while the clock enable is low.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            s <= '{sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_d: 1'b0,
                   sel_n_s1: 1'b1, sel_n_s2: 1'b1, mosi_s1: 1'b0, mosi_s2: 1'b0,
                   bit_cnt: 6'd0, shift_in: 32'h00000000, shift_out: 24'h000000,
                   reading: 1'b0, miso: 1'b0, miso_oe: 1'b0, wr_go: 1'b0,
                   wr_addr: 7'h00, wr_data: 24'h000000, cal_start: 1'b0,
                   nv_strobe: 1'b0, nv_program_enable: RST_NV_ENABLE,
                   nv_addr: RST_NV_ADDR, self_test_mode_on: RST_ST_ENABLE,
                   fine_eff: 4'h0, bit0_eff: 1'b0};
        end else if (i_clk_en) begin
            s <= next_s;
        end
    end

    assign o_spi_miso          = s.miso;
    assign o_spi_miso_oe       = s.miso_oe;
    assign o_fine_code_eff     = s.fine_eff;
    assign o_settings_bit0_eff = s.bit0_eff;
    assign o_stored_settings   = nv.image;

    // Checks. The clock enable is held high in these relations, since a
    // frozen clock would stretch every figure below.
    sequence s_wr(logic [6:0] a);
        s.wr_go && s.wr_addr == a && i_clk_en;
    endsequence

    sequence s_burn_go;
        s.nv_strobe && s.nv_program_enable && !nv.busy && i_clk_en;
    endsequence

    sequence s_start(logic mode);
        s.cal_start && s.self_test_mode_on == mode && !cal.busy && !cal.st_running
            && i_clk_en;
    endsequence

    code_range_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset) cal.code <= FINE_CODE_MAX)
        else $error("Calibrated fine code above the legal maximum.");

    cal_busy_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_start(1'b0) ##1 i_clk_en |-> cal.busy && !cal.st_running)
        else $error("Calibration did not raise its busy flag after a start.");

    strobe_start_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_wr(A_CAL_STROBE) ##1 i_clk_en |-> s.cal_start)
        else $error("Strobe register write did not issue a start.");

    st_mode_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_start(1'b1) ##1 i_clk_en |-> cal.st_running && !cal.busy)
        else $error("Self-test mode start ran a normal calibration.");

    st_length_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_start(1'b1) |=> (i_clk_en && cal.st_running) [*8])
        else $error("Self-test busy flag dropped too early.");

    nv_burn_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_burn_go |=> (i_clk_en && nv.busy) [*8])
        else $error("OTP busy flag not held during a burn.");

    nv_gate_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s.nv_strobe && !s.nv_program_enable && !nv.busy && i_clk_en |=> !nv.busy)
        else $error("OTP burn began while programming was disabled.");

    nv_addr_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_wr(A_NV_ADDR) |=> s.nv_addr == $past(s.wr_data[3:0]))
        else $error("OTP bit address not taken from the write.");

    status_ro_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_wr(A_CAL_STATUS) |=> !s.cal_start && !s.nv_strobe && $stable(s.nv_addr))
        else $error("Write to the status register had an effect.");

    flag_gate_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        !nv.image[F_NV_PRG_FLAG] && i_clk_en |=> !o_settings_bit0_eff)
        else $error("Settings bit 0 passed while the programmed flag is clear.");

    force_code_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        i_force_code && i_clk_en |=> o_fine_code_eff == $past(i_fine_override))
        else $error("Forced fine code not applied to the filter.");

    // Read capture: the word latched at the header's last bit matches the register map.
    sequence s_hdr(logic [6:0] lo, logic [6:0] hi);
        selected && sclk_rise && s.bit_cnt == HDR_BITS - 6'd1 && i_clk_en
            && frame_nxt[6:0] >= lo && frame_nxt[6:0] <= hi;
    endsequence

    status_map_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset) s_hdr(A_CAL_STATUS, A_CAL_STATUS)
        |=> s.shift_out == {18'h00000, $past(nv.busy), $past(cal.busy), $past(cal.code)})
        else $error("Status read word does not match the flags.");

    raw_map_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset) s_hdr(A_RAW_COUNT, A_RAW_COUNT)
        |=> s.shift_out == $past(cal.raw_count))
        else $error("Raw count read word does not match the counter.");

    image_map_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset) s_hdr(A_NV_IMAGE, A_NV_IMAGE)
        |=> s.shift_out == {9'h000, $past(nv.image[14:0])})
        else $error("OTP image read word does not match the store.");

    result_map_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset) s_hdr(A_ST_RESULT, A_ST_RESULT)
        |=> s.shift_out == {7'h00, $past(cal.st_running), $past(cal.signature)})
        else $error("Self-test read word does not match the engine.");

    thr_zero_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset) s_hdr(A_THR_FIRST, A_THR_LAST)
        |=> s.shift_out == 24'h000000)
        else $error("Threshold range did not read zero.");

    code_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset) !cal.busy && i_clk_en |=> $stable(cal.code))
        else $error("Fine code changed outside a calibration.");

    raw_step_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset) cal.busy && cal.raw_count < 24'hff0000
        && i_clk_en |=> cal.raw_count == $past(cal.raw_count) + 24'($past(i_clock_period)))
        else $error("Raw count step differs from the clock period.");

    nv_idle_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset) !nv.busy && i_clk_en |=> $stable(nv.image))
        else $error("OTP image changed with no burn running.");

    mode_wr_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_wr(A_ST_ENABLE) |=> s.self_test_mode_on == $past(s.wr_data[0]))
        else $error("Self-test enable not taken from the write.");

    fine_cal_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        !i_force_code && i_clk_en |=> o_fine_code_eff == $past(cal.code))
        else $error("Filter fine code does not follow calibration.");

    flag_pass_a: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        nv.image[F_NV_PRG_FLAG] && i_clk_en |=> o_settings_bit0_eff == $past(i_settings_bit0))
        else $error("Settings bit 0 blocked while the programmed flag is set.");
endmodule
`default_nettype wire

// >>> test/spi_host.sv
// Purpose: Serial host model that sends one register frame at a time.
// Assumes: 800 ns serial period; the clock stands low between frames.
// Notes:   Read bits are taken late in the high phase, after the slave shifts.
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    output logic      o_sclk,
    output logic      o_sel_n,
    output logic      o_mosi,
    input  wire logic i_miso
);
    initial begin
        o_sclk  = 1'b0;
        o_sel_n = 1'b1;
        o_mosi  = 1'b0;
    end
    // The odd lead-in keeps frames out of phase with the system clock.
    task automatic xfer(input logic [31:0] f, output logic [23:0] rd);
        rd = 24'h0;
        #37 o_sel_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            o_mosi = f[i];
            #400 o_sclk = 1'b1;
            #390 if (i < 24) rd[i] = i_miso;
            #10 o_sclk = 1'b0;
        end
        #400 o_sel_n = 1'b1;
        o_mosi = ~o_mosi; // A released line must not keep showing the last bit.
        #800;
    endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the status, OTP and self-test registers.
// Assumes: Frames come from the host model; the comparator is driven here.
// Notes:   Codes are predicted from the raw count read back.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module tb_top;
    import filt_regs_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        rc_done = 1'b0;
    logic        force_c = 1'b0;
    logic        set0    = 1'b1;
    logic [8:0]  adj_in  = 9'h000;
    logic        sclk, sel_n, mosi, miso, oe, bit0;
    logic [3:0]  fine;
    logic [15:0] stored;
    logic [15:0] img     = 16'h0000;
    logic [23:0] s;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cycles      = 0;

    spi_host host (.o_sclk(sclk), .o_sel_n(sel_n), .o_mosi(mosi), .i_miso(miso));
    filt_status_regs dut (.i_clk_sys(clk_sys), .i_reset(reset), .i_clk_en(1'b1),
        .i_spi_clk(sclk), .i_spi_sel_n(sel_n), .i_spi_mosi(mosi), .o_spi_miso(miso),
        .o_spi_miso_oe(oe), .i_rc_done(rc_done), .i_force_code(force_c),
        .i_fine_override(4'h5), .i_clock_period(15'h0064), .i_meas_adj(adj_in),
        .i_settings_bit0(set0), .o_settings_bit0_eff(bit0),
        .o_fine_code_eff(fine), .o_stored_settings(stored));

    always #50 clk_sys = ~clk_sys;

    // A hang shows up as a mismatch rather than a silent stall.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            $display("[ERR] %0t timeout", $time);
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [23:0] d);
        logic [23:0] x;
        host.xfer({1'b0, a, d}, x);
    endtask
    task automatic rd(input logic [6:0] a, output logic [23:0] d);
        host.xfer({1'b1, a, 24'h0}, d);
    endtask
    task automatic rchk(input logic [6:0] a, input logic [23:0] e);
        logic [23:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask
    // One calibration; the count is frozen by the comparator before it is read.
    task automatic cal(input logic [8:0] adj);
        logic [23:0] r;
        longint      v;
        step();
        adj_in = adj;
        wr(A_CAL_STROBE, {15'h0, adj});
        rd(A_CAL_STATUS, s);
        `CHK(s[F_CAL_BUSY], 1'b1)
        step();
        rc_done = 1'b1;
        rd(A_CAL_STATUS, s);
        rd(A_RAW_COUNT, r);
        step();
        rc_done = 1'b0;
        v = longint'(r) + longint'($signed(adj)) * 1024 - longint'(CODE_BASE_PS);
        v = (v < 0) ? 0 : (((v >>> 10) > 11) ? 11 : (v >>> 10));
        `CHK(s, 24'(v))
        `CHK(r !== 24'h0, 1'b1)
        `CHK(fine, 4'(v))
    endtask

    // Main sequence: reset values, access kinds, calibration, self-test, burns.
    initial begin
        logic [6:0] za [10] = '{A_CAL_STATUS, A_RAW_COUNT, A_NV_IMAGE, A_ST_RESULT,
            A_THR_FIRST, 7'h15, A_THR_LAST, A_NV_ENABLE, A_NV_ADDR, A_ST_ENABLE};
        logic [3:0] burn [4] = '{4'hd, 4'h3, 4'he, 4'hf};
        repeat (5) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (4) step();
        foreach (za[i]) rchk(za[i], 24'h0);
        foreach (za[i]) begin
            wr(za[i], 24'hffffff);
            rchk(za[i], (i < 7) ? 24'h0 : ((i == 8) ? 24'hf : 24'h1));
        end
        wr(A_NV_ENABLE, 24'h0);
        wr(A_NV_STROBE, 24'hffffff);
        rchk(A_CAL_STATUS, 24'h0);
        rchk(A_NV_IMAGE, 24'h0);
        `CHK(bit0, 1'b0)
        wr(A_ST_ENABLE, 24'h0);
        cal(9'h000);
        cal(9'h1f8);
        cal(9'h010);
        step();
        force_c = 1'b1;
        repeat (2) step();
        `CHK(fine, 4'h5)
        force_c = 1'b0;
        // With the comparator low a normal calibration would stay busy.
        wr(A_ST_ENABLE, 24'h1);
        wr(A_CAL_STROBE, 24'h0);
        rd(A_ST_RESULT, s);
        `CHK(s[F_ST_RUNNING], 1'b0)
        `CHK(s[15:0] !== RST_SIGNATURE, 1'b1)
        rd(A_CAL_STATUS, s);
        `CHK(s[F_CAL_BUSY], 1'b0)
        wr(A_ST_ENABLE, 24'h0);
        wr(A_NV_ENABLE, 24'h1);
        foreach (burn[i]) begin
            wr(A_NV_ADDR, {20'h0, burn[i]});
            wr(A_NV_STROBE, 24'h0);
            rd(A_CAL_STATUS, s);
            `CHK(s[F_NV_BUSY], 1'b1)
            for (int n = 0; n < 8 && s[F_NV_BUSY] !== 1'b0; n++) rd(A_CAL_STATUS, s);
            img[burn[i]] = 1'b1;
            rchk(A_NV_IMAGE, {9'h0, img[14:0]});
            `CHK(stored, img)
            `CHK(bit0, img[13])
        end
        step();
        set0 = 1'b0;
        repeat (2) step();
        `CHK(bit0, 1'b0)
        `CHK(oe, 1'b0)
        conclude();
    end
endmodule
`default_nettype wire
